// ==== design/fdf_front_core.v ====
// Instruction fetch, three-way decode with folding and fusion, dispatch and retirement
`timescale 1ns/1ps
`default_nettype none
`include "fdf_defines.vh"
module fdf_front_core #(
    parameter AW = 32,
    parameter CACHE_BYTES = `FDF_CACHE_BYTES,
    parameter BP_ENTRIES = 16,
    parameter ROB_DEPTH = 16,
    parameter FIFO_DEPTH = 8,
    parameter [AW-1:0] RESET_PC = {AW{1'b0}}
) (
    input wire clk_i,
    input wire rstn_i,
    output wire mem_req_o,
    output wire [AW-1:0] mem_addr_o,
    input wire mem_ack_i,
    input wire [`FDF_LINE_W-1:0] mem_data_i,
    input wire flush_i,
    input wire [AW-1:0] flush_pc_i,
    input wire bp_upd_valid_i,
    input wire [AW-1:0] bp_upd_pc_i,
    input wire bp_upd_taken_i,
    input wire [AW-1:0] bp_upd_target_i,
    input wire [`FDF_OFF_W-1:0] bp_upd_end_i,
    input wire [`FDF_DISP_MAX-1:0] port_free_i,
    output wire [`FDF_DISP_MAX-1:0] disp_valid_o,
    output wire [`FDF_DISP_MAX*$clog2(ROB_DEPTH)-1:0] disp_tag_o,
    output wire [`FDF_DISP_MAX*`FDF_UOP_W-1:0] disp_uop_o,
    input wire cmpl_valid_i,
    input wire [$clog2(ROB_DEPTH)-1:0] cmpl_tag_i,
    output wire [1:0] retire_cnt_o,
    output wire [`FDF_RET_MAX*`FDF_UOP_W-1:0] retire_uop_o
);
    // ========================================
    // Constants and helpers
    localparam OW = `FDF_OFF_W;
    localparam LINES = CACHE_BYTES / `FDF_BLK_BYTES;
    localparam IW = $clog2(LINES);
    localparam TW = AW - IW - OW;
    localparam BUF_W = `FDF_BUF_BYTES * `FDF_BYTE_W;
    localparam UW = `FDF_UOP_W;
    localparam CW = `FDF_GRP_CNT_W;
    localparam GRP_W = CW + `FDF_GRP_SLOTS * UW;
    localparam RA = $clog2(ROB_DEPTH);
    localparam UOP_DEP = `FDF_DEP_BIT + `FDF_UOP_OP_LSB;
    localparam [AW-1:0] BLK_INC = `FDF_BLK_BYTES;
    localparam [5:0] ROOM_MAX = `FDF_BUF_BYTES - `FDF_BLK_BYTES;
    localparam S_LOOK = 1'b0;
    localparam S_MISS = 1'b1;

    function [2:0] ucnt;
        input [7:0] op;
        begin
            case (op[`FDF_CLS_MSB:`FDF_CLS_LSB])
                `FDF_CLS_LOAD: ucnt = op[`FDF_NOFUSE_BIT] ? 3'h2 : 3'h1;
                `FDF_CLS_STORE: ucnt = 3'h1;
                `FDF_CLS_STACK: ucnt = 3'h1;
                `FDF_CLS_VLOAD: ucnt = 3'h2;
                `FDF_CLS_CPLX: ucnt = 3'h3;
                `FDF_CLS_LONG: ucnt = 3'h4;
                default: ucnt = 3'h1;
            endcase
        end
    endfunction

    function [2:0] ilen;
        input [7:0] op;
        begin
            ilen = {1'b0, op[`FDF_LEN_MSB:`FDF_LEN_LSB]} + 3'h1;
        end
    endfunction

    // Micro-op word: opcode, index within instruction, fused flag, folded flag
    function [UW-1:0] mk_uop;
        input [7:0] op;
        input [1:0] idx;
        reg [2:0] c;
        begin
            c = op[`FDF_CLS_MSB:`FDF_CLS_LSB];
            mk_uop = {op, idx, (c == `FDF_CLS_STORE) || (c == `FDF_CLS_LOAD && !op[`FDF_NOFUSE_BIT]),
                      c == `FDF_CLS_STACK};
        end
    endfunction

    function [RA-1:0] wrap;
        input [RA-1:0] base;
        input [RA:0] off;
        begin
            wrap = base + off[RA-1:0];
        end
    endfunction

    // ========================================
    // Instruction cache and fetch
    reg [`FDF_LINE_W-1:0] line_ff [0:LINES-1];
    reg [TW-1:0] ctag_ff [0:LINES-1];
    reg [LINES-1:0] lval_ff;
    reg state_ff;
    reg [AW-1:0] pc_ff;
    reg [AW-1:0] miss_addr_ff;
    reg [BUF_W-1:0] buf_ff;
    reg [5:0] cnt_ff;
    wire bp_hit;
    wire bp_taken;
    wire [AW-1:0] bp_target;
    wire [OW-1:0] bp_end;
    wire [IW-1:0] fidx = pc_ff[OW +: IW];
    wire [OW-1:0] foff = pc_ff[OW-1:0];
    wire [IW-1:0] midx = miss_addr_ff[OW +: IW];
    wire chit = lval_ff[fidx] && (ctag_ff[fidx] == pc_ff[AW-1:AW-TW]);
    wire br_cut = bp_hit && bp_taken && (bp_end >= foff);
    wire [4:0] app_len = br_cut ? ({1'b0, bp_end} - {1'b0, foff} + 5'h01) : (5'h10 - {1'b0, foff});
    wire fetch_go = (state_ff == S_LOOK) && chit && (cnt_ff <= ROOM_MAX) && !flush_i;
    wire miss_go = (state_ff == S_LOOK) && !chit && !flush_i;
    wire [AW-1:0] pc_seq = {pc_ff[AW-1:OW], {OW{1'b0}}} + BLK_INC;

    assign mem_req_o = (state_ff == S_MISS);
    assign mem_addr_o = miss_addr_ff;

    fdf_branch_pred #(.AW(AW), .ENTRIES(BP_ENTRIES)) u_bp (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .lk_pc_i(pc_ff),
        .lk_hit_o(bp_hit),
        .lk_taken_o(bp_taken),
        .lk_target_o(bp_target),
        .lk_end_o(bp_end),
        .upd_valid_i(bp_upd_valid_i),
        .upd_pc_i(bp_upd_pc_i),
        .upd_taken_i(bp_upd_taken_i),
        .upd_target_i(bp_upd_target_i),
        .upd_end_i(bp_upd_end_i)
    );

    // Cache data has no reset; valid bits guard it
    always @(posedge clk_i) begin
        if (state_ff == S_MISS && mem_ack_i) begin
            line_ff[midx] <= mem_data_i;
            ctag_ff[midx] <= miss_addr_ff[AW-1:AW-TW];
        end
    end

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff <= S_LOOK;
            pc_ff <= RESET_PC;
            miss_addr_ff <= {AW{1'b0}};
            lval_ff <= {LINES{1'b0}};
        end else begin
            case (state_ff)
                S_LOOK: begin
                    if (miss_go) begin
                        state_ff <= S_MISS;
                        miss_addr_ff <= {pc_ff[AW-1:OW], {OW{1'b0}}};
                    end
                end
                S_MISS: begin
                    // A refill in flight completes even across a flush
                    if (mem_ack_i) begin
                        state_ff <= S_LOOK;
                        lval_ff[midx] <= 1'b1;
                    end
                end
                default: state_ff <= S_LOOK;
            endcase
            if (flush_i) begin
                pc_ff <= flush_pc_i;
            end else if (fetch_go) begin
                pc_ff <= br_cut ? bp_target : pc_seq;
            end
        end
    end

    // ========================================
    // Three decoders
    reg [7:0] op0, op1, op2;
    reg [2:0] l0, l1, l2;
    reg [5:0] s1, s2, used;
    reg v0, v1, v2;
    reg [GRP_W-1:0] grp;
    reg [CW-1:0] gcnt;
    integer k;
    wire fifo_in_ready;

    always @* begin
        op0 = buf_ff[7:0];
        l0 = ilen(op0);
        s1 = {3'h0, l0};
        op1 = buf_ff[s1*`FDF_BYTE_W +: `FDF_BYTE_W];
        l1 = ilen(op1);
        s2 = s1 + {3'h0, l1};
        op2 = buf_ff[s2*`FDF_BYTE_W +: `FDF_BYTE_W];
        l2 = ilen(op2);
        v0 = (cnt_ff >= s1) && (ucnt(op0) <= `FDF_DEC0_MAX);
        v1 = v0 && (cnt_ff >= s2) && (ucnt(op1) == 3'h1);
        v2 = v1 && (cnt_ff >= s2 + {3'h0, l2}) && (ucnt(op2) == 3'h1);
        grp = {GRP_W{1'b0}};
        gcnt = ucnt(op0);
        for (k = 0; k < `FDF_DEC0_MAX; k = k + 1) begin
            if (k < gcnt) begin
                grp[CW + k*UW +: UW] = mk_uop(op0, k[1:0]);
            end
        end
        if (v1) begin
            grp[CW + gcnt*UW +: UW] = mk_uop(op1, 2'h0);
            gcnt = gcnt + 3'h1;
        end
        if (v2) begin
            grp[CW + gcnt*UW +: UW] = mk_uop(op2, 2'h0);
            gcnt = gcnt + 3'h1;
        end
        grp[CW-1:0] = gcnt;
        used = s1;
        if (v1) begin
            used = s2;
        end
        if (v2) begin
            used = s2 + {3'h0, l2};
        end
        if (!(v0 && fifo_in_ready && !flush_i)) begin
            used = 6'h00;
        end
    end

    // Byte queue: consumed bytes shift out, fetched bytes land above the remainder
    wire [5:0] rem = cnt_ff - used;
    wire [BUF_W-1:0] blk_bytes = {{(BUF_W-`FDF_LINE_W){1'b0}}, line_ff[fidx] >> (foff*`FDF_BYTE_W)};
    wire [BUF_W-1:0] blk_mask = ~({BUF_W{1'b1}} << (app_len*`FDF_BYTE_W));
    wire [BUF_W-1:0] nxt_buf = (buf_ff >> (used*`FDF_BYTE_W)) |
                               (fetch_go ? ((blk_bytes & blk_mask) << (rem*`FDF_BYTE_W)) : {BUF_W{1'b0}});
    wire [5:0] nxt_cnt = rem + (fetch_go ? {1'b0, app_len} : 6'h00);

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            buf_ff <= {BUF_W{1'b0}};
            cnt_ff <= 6'h00;
        end else if (flush_i) begin
            buf_ff <= {BUF_W{1'b0}};
            cnt_ff <= 6'h00;
        end else begin
            buf_ff <= nxt_buf;
            cnt_ff <= nxt_cnt;
        end
    end

    // ========================================
    // Issue queue and completion buffer
    wire fq_valid;
    wire [GRP_W-1:0] fq_data;
    reg [1:0] st_ff [0:ROB_DEPTH-1];
    reg [UW-1:0] uop_ff [0:ROB_DEPTH-1];
    reg [RA-1:0] head_ff, tail_ff;
    reg [RA:0] num_ff;
    wire [CW-1:0] fq_cnt = fq_data[CW-1:0];
    wire [RA:0] rob_free = ROB_DEPTH[RA:0] - num_ff;
    wire pop = fq_valid && ({{(RA+1-CW){1'b0}}, fq_cnt} <= rob_free) && !flush_i;

    fdf_fifo #(.W(GRP_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .flush_i(flush_i),
        .in_valid_i(v0 && !flush_i),
        .in_ready_o(fifo_in_ready),
        .in_data_i(grp),
        .out_valid_o(fq_valid),
        .out_ready_i(pop),
        .out_data_o(fq_data)
    );

    reg [ROB_DEPTH-1:0] disp_mask;
    reg [`FDF_DISP_MAX-1:0] nxt_dv;
    reg [`FDF_DISP_MAX*RA-1:0] nxt_dt;
    reg [`FDF_DISP_MAX*UW-1:0] nxt_du;
    reg [`FDF_RET_MAX*UW-1:0] nxt_ru;
    reg [1:0] nxt_rc;
    reg [RA-1:0] ri, pi;
    reg stop;
    integer i, d, j;

    always @* begin
        disp_mask = {ROB_DEPTH{1'b0}};
        nxt_dv = {`FDF_DISP_MAX{1'b0}};
        nxt_dt = {(`FDF_DISP_MAX*RA){1'b0}};
        nxt_du = {(`FDF_DISP_MAX*UW){1'b0}};
        nxt_ru = {(`FDF_RET_MAX*UW){1'b0}};
        nxt_rc = 2'h0;
        stop = 1'b0;
        d = 0;
        ri = head_ff;
        pi = head_ff;
        // Oldest first; a busy lane closes the lanes above it for this cycle
        for (i = 0; i < ROB_DEPTH; i = i + 1) begin
            ri = wrap(head_ff, i[RA:0]);
            pi = ri - {{(RA-1){1'b0}}, 1'b1};
            if (i < num_ff && st_ff[ri] == `FDF_ST_WAIT && d < `FDF_DISP_MAX &&
                (i == 0 || !uop_ff[ri][UOP_DEP] || st_ff[pi] == `FDF_ST_DONE)) begin
                if (port_free_i[d]) begin
                    disp_mask[ri] = 1'b1;
                    nxt_dv[d] = 1'b1;
                    nxt_dt[d*RA +: RA] = ri;
                    nxt_du[d*UW +: UW] = uop_ff[ri];
                    d = d + 1;
                end
            end
        end
        for (i = 0; i < `FDF_RET_MAX; i = i + 1) begin
            ri = wrap(head_ff, i[RA:0]);
            if (!stop && i < num_ff && st_ff[ri] == `FDF_ST_DONE) begin
                nxt_ru[i*UW +: UW] = uop_ff[ri];
                nxt_rc = nxt_rc + 2'h1;
            end else begin
                stop = 1'b1;
            end
        end
    end

    reg [`FDF_DISP_MAX-1:0] disp_valid_ff;
    reg [`FDF_DISP_MAX*RA-1:0] disp_tag_ff;
    reg [`FDF_DISP_MAX*UW-1:0] disp_uop_ff;
    reg [1:0] retire_cnt_ff;
    reg [`FDF_RET_MAX*UW-1:0] retire_uop_ff;
    wire [RA:0] ins = pop ? {{(RA+1-CW){1'b0}}, fq_cnt} : {(RA+1){1'b0}};

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (j = 0; j < ROB_DEPTH; j = j + 1) begin
                st_ff[j] <= `FDF_ST_FREE;
                uop_ff[j] <= {UW{1'b0}};
            end
            head_ff <= {RA{1'b0}};
            tail_ff <= {RA{1'b0}};
            num_ff <= {(RA+1){1'b0}};
            disp_valid_ff <= {`FDF_DISP_MAX{1'b0}};
            disp_tag_ff <= {(`FDF_DISP_MAX*RA){1'b0}};
            disp_uop_ff <= {(`FDF_DISP_MAX*UW){1'b0}};
            retire_cnt_ff <= 2'h0;
            retire_uop_ff <= {(`FDF_RET_MAX*UW){1'b0}};
        end else if (flush_i) begin
            for (j = 0; j < ROB_DEPTH; j = j + 1) begin
                st_ff[j] <= `FDF_ST_FREE;
            end
            head_ff <= {RA{1'b0}};
            tail_ff <= {RA{1'b0}};
            num_ff <= {(RA+1){1'b0}};
            disp_valid_ff <= {`FDF_DISP_MAX{1'b0}};
            retire_cnt_ff <= 2'h0;
        end else begin
            for (j = 0; j < ROB_DEPTH; j = j + 1) begin
                if (disp_mask[j]) begin
                    st_ff[j] <= `FDF_ST_ISSUED;
                end
                if (cmpl_valid_i && cmpl_tag_i == j[RA-1:0] && st_ff[j] == `FDF_ST_ISSUED) begin
                    st_ff[j] <= `FDF_ST_DONE;
                end
            end
            for (j = 0; j < `FDF_RET_MAX; j = j + 1) begin
                if (j < nxt_rc) begin
                    st_ff[wrap(head_ff, j[RA:0])] <= `FDF_ST_FREE;
                end
            end
            for (j = 0; j < `FDF_GRP_SLOTS; j = j + 1) begin
                if (j < ins) begin
                    st_ff[wrap(tail_ff, j[RA:0])] <= `FDF_ST_WAIT;
                    uop_ff[wrap(tail_ff, j[RA:0])] <= fq_data[CW + j*UW +: UW];
                end
            end
            head_ff <= wrap(head_ff, {{(RA-1){1'b0}}, nxt_rc});
            tail_ff <= wrap(tail_ff, ins);
            num_ff <= num_ff + ins - {{(RA-1){1'b0}}, nxt_rc};
            disp_valid_ff <= nxt_dv;
            disp_tag_ff <= nxt_dt;
            disp_uop_ff <= nxt_du;
            retire_cnt_ff <= nxt_rc;
            retire_uop_ff <= nxt_ru;
        end
    end

    assign disp_valid_o = disp_valid_ff;
    assign disp_tag_o = disp_tag_ff;
    assign disp_uop_o = disp_uop_ff;
    assign retire_cnt_o = retire_cnt_ff;
    assign retire_uop_o = retire_uop_ff;
endmodule
`default_nettype wire

// ==== design/fdf_defines.vh ====
// Shared constants of the fetch, decode, fuse and dispatch front end
`ifndef FDF_DEFINES_VH
`define FDF_DEFINES_VH
`define FDF_BYTE_W 8
`define FDF_BLK_BYTES 16
`define FDF_OFF_W 4
`define FDF_LINE_W 128
`define FDF_BUF_BYTES 32
`define FDF_CACHE_BYTES 32768
`define FDF_UOP_W 12
`define FDF_UOP_OP_LSB 4
`define FDF_GRP_SLOTS 6
`define FDF_GRP_CNT_W 3
`define FDF_DEC0_MAX 4
`define FDF_DISP_MAX 5
`define FDF_RET_MAX 3
`define FDF_LEN_MSB 1
`define FDF_LEN_LSB 0
`define FDF_CLS_MSB 4
`define FDF_CLS_LSB 2
`define FDF_NOFUSE_BIT 5
`define FDF_DEP_BIT 6
`define FDF_CLS_ALU 3'h0
`define FDF_CLS_LOAD 3'h1
`define FDF_CLS_STORE 3'h2
`define FDF_CLS_STACK 3'h3
`define FDF_CLS_VLOAD 3'h4
`define FDF_CLS_CPLX 3'h5
`define FDF_CLS_LONG 3'h6
`define FDF_CLS_BRANCH 3'h7
`define FDF_ST_FREE 2'h0
`define FDF_ST_WAIT 2'h1
`define FDF_ST_ISSUED 2'h2
`define FDF_ST_DONE 2'h3
`endif

// ==== design/fdf_fifo.v ====
// Flop based FIFO between the decoders and the completion buffer
`timescale 1ns/1ps
`default_nettype none
module fdf_fifo #(
    parameter W = 75,
    parameter DEPTH = 8
) (
    input wire clk_i,
    input wire rstn_i,
    input wire flush_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [W-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [W-1:0] out_data_o
);
    localparam AW = $clog2(DEPTH);
    reg [W-1:0] mem_ff [0:DEPTH-1];
    reg [AW:0] wr_ff;
    reg [AW:0] rd_ff;
    wire empty = (wr_ff == rd_ff);
    wire full = (wr_ff[AW-1:0] == rd_ff[AW-1:0]) && (wr_ff[AW] != rd_ff[AW]);
    wire push = in_valid_i && !full;
    wire pop = out_ready_i && !empty;

    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem_ff[rd_ff[AW-1:0]];

    always @(posedge clk_i) begin
        if (push) begin
            mem_ff[wr_ff[AW-1:0]] <= in_data_i;
        end
    end

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ff <= {(AW+1){1'b0}};
            rd_ff <= {(AW+1){1'b0}};
        end else if (flush_i) begin
            wr_ff <= {(AW+1){1'b0}};
            rd_ff <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ff <= wr_ff + {{AW{1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ff <= rd_ff + {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

// ==== design/fdf_branch_pred.v ====
// Branch target predictor table, indexed by fetch block address
`timescale 1ns/1ps
`default_nettype none
`include "fdf_defines.vh"
module fdf_branch_pred #(
    parameter AW = 32,
    parameter ENTRIES = 16
) (
    input wire clk_i,
    input wire rstn_i,
    input wire [AW-1:0] lk_pc_i,
    output wire lk_hit_o,
    output wire lk_taken_o,
    output wire [AW-1:0] lk_target_o,
    output wire [`FDF_OFF_W-1:0] lk_end_o,
    input wire upd_valid_i,
    input wire [AW-1:0] upd_pc_i,
    input wire upd_taken_i,
    input wire [AW-1:0] upd_target_i,
    input wire [`FDF_OFF_W-1:0] upd_end_i
);
    localparam IW = $clog2(ENTRIES);
    localparam TW = AW - IW - `FDF_OFF_W;
    reg [ENTRIES-1:0] val_ff;
    reg [1:0] ctr_ff [0:ENTRIES-1];
    reg [TW-1:0] tag_ff [0:ENTRIES-1];
    reg [AW-1:0] tgt_ff [0:ENTRIES-1];
    reg [`FDF_OFF_W-1:0] end_ff [0:ENTRIES-1];
    wire [IW-1:0] li = lk_pc_i[`FDF_OFF_W +: IW];
    wire [IW-1:0] ui = upd_pc_i[`FDF_OFF_W +: IW];
    wire [TW-1:0] ut = upd_pc_i[AW-1:AW-TW];
    wire uhit = val_ff[ui] && (tag_ff[ui] == ut);
    integer i;

    // Direction from a two-bit counter, target from the entry
    assign lk_hit_o = val_ff[li] && (tag_ff[li] == lk_pc_i[AW-1:AW-TW]);
    assign lk_taken_o = ctr_ff[li][1];
    assign lk_target_o = tgt_ff[li];
    assign lk_end_o = end_ff[li];

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            val_ff <= {ENTRIES{1'b0}};
            for (i = 0; i < ENTRIES; i = i + 1) begin
                ctr_ff[i] <= 2'h0;
                tag_ff[i] <= {TW{1'b0}};
                tgt_ff[i] <= {AW{1'b0}};
                end_ff[i] <= {`FDF_OFF_W{1'b0}};
            end
        end else if (upd_valid_i) begin
            // Only taken branches allocate, so the table is not wasted on fall-through
            if (uhit) begin
                if (upd_taken_i && ctr_ff[ui] != 2'h3) begin
                    ctr_ff[ui] <= ctr_ff[ui] + 2'h1;
                end else if (!upd_taken_i && ctr_ff[ui] != 2'h0) begin
                    ctr_ff[ui] <= ctr_ff[ui] - 2'h1;
                end
                if (upd_taken_i) begin
                    tgt_ff[ui] <= upd_target_i;
                    end_ff[ui] <= upd_end_i;
                end
            end else if (upd_taken_i) begin
                val_ff[ui] <= 1'b1;
                ctr_ff[ui] <= 2'h2;
                tag_ff[ui] <= ut;
                tgt_ff[ui] <= upd_target_i;
                end_ff[ui] <= upd_end_i;
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/fdf_front_monitor.sv ====
// Port checker of the fetch, decode and dispatch front end
`timescale 1ns/1ps
`default_nettype none
module fdf_front_monitor (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic mem_req_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic mem_ack_i,
    input wire logic flush_i,
    input wire logic [4:0] port_free_i,
    input wire logic [4:0] disp_valid_o,
    input wire logic [19:0] disp_tag_o,
    input wire logic [59:0] disp_uop_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // ==========
    // Dependence bit of lanes 1 to 4
    wire logic [3:0] deps = {disp_uop_o[58], disp_uop_o[46], disp_uop_o[34], disp_uop_o[22]};
    // Lane holds the entry right after the one in the lane below, i.e. its producer
    wire logic [3:0] after_below = {disp_tag_o[19:16] == disp_tag_o[15:12] + 4'h1,
        disp_tag_o[15:12] == disp_tag_o[11:8] + 4'h1, disp_tag_o[11:8] == disp_tag_o[7:4] + 4'h1,
        disp_tag_o[7:4] == disp_tag_o[3:0] + 4'h1};
    AST_MEM_HOLD: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
        else $error("refill request dropped or moved before ack");
    AST_MEM_ALIGN: assert property (mem_req_o |-> mem_addr_o[3:0] == 4'h0)
        else $error("refill address not block aligned");
    AST_MEM_DROP: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
        else $error("refill request held after ack");
    AST_DISP_PORT: assert property ((disp_valid_o & ~$past(port_free_i)) == 5'h0)
        else $error("dispatch on a busy lane");
    AST_DISP_LANES: assert property (((disp_valid_o + 5'h1) & disp_valid_o) == 5'h0)
        else $error("dispatch lanes not filled from lane 0");
    AST_DISP_FLUSH: assert property (flush_i |=> disp_valid_o == 5'h0)
        else $error("dispatch right after flush");
    AST_DISP_DEP: assert property ((disp_valid_o[4:1] & disp_valid_o[3:0] & deps & after_below) == 4'h0)
        else $error("dependent uop sent beside its producer");
    AST_TAG_DIFF: assert property (&disp_valid_o[1:0] |-> disp_tag_o[3:0] != disp_tag_o[7:4])
        else $error("two lanes carry one buffer entry");
endmodule
bind fdf_front_core fdf_front_monitor u_mon (.clk_i(clk_i), .rstn_i(rstn_i), .mem_req_o(mem_req_o),
    .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .flush_i(flush_i), .port_free_i(port_free_i),
    .disp_valid_o(disp_valid_o), .disp_tag_o(disp_tag_o), .disp_uop_o(disp_uop_o));
`default_nettype wire

// ==== sim/fdf_mem_model.sv ====
// Instruction memory that answers front end refills
`timescale 1ns/1ps
`default_nettype none
module fdf_mem_model (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [3:0] lat_i,
    input wire logic req_i,
    input wire logic [31:0] addr_i,
    output logic ack_o,
    output logic [127:0] data_o
);
    logic [7:0] prog [0:255];
    logic [3:0] wait_ff;
    integer i;
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_o <= 1'b0;
            data_o <= 128'h0;
            wait_ff <= 4'h0;
        end else begin
            ack_o <= 1'b0;
            // Stale line inverted so nobody can lean on it
            data_o <= ~data_o;
            if (req_i && !ack_o) begin
                wait_ff <= wait_ff + 4'h1;
                if (wait_ff >= lat_i) begin
                    ack_o <= 1'b1;
                    wait_ff <= 4'h0;
                    for (i = 0; i < 16; i = i + 1)
                        data_o[8*i +: 8] <= prog[addr_i[7:0] + i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/fdf_front_core_tb.sv ====
// Testbench of the front end with a refill memory model
`timescale 1ns/1ps
`default_nettype none
module fdf_front_core_tb;
    logic clk_i = 1'b0, rstn_i = 1'b0, flush_i = 1'b0, bp_v = 1'b0, bp_tk = 1'b1, cmpl_v = 1'b0, mreq, mack;
    logic [31:0] maddr, flush_pc = 32'h0, bp_pc = 32'h80;
    logic [127:0] mdata;
    logic [3:0] lat = 4'h3, cmpl_tag = 4'h0;
    logic [4:0] port_free = 5'h1F, dv;
    logic [19:0] dtag;
    logic [59:0] duop;
    logic [1:0] rcnt;
    logic [35:0] ruop;
    logic [7:0] a;
    logic [7:0] mix [12] = '{8'h01, 8'h06, 8'h24, 8'h09, 8'h0C, 8'h13, 8'h14, 8'h19, 8'h1C, 8'h40, 8'h40, 8'h01};
    logic [3:0] tq[$];
    logic [11:0] got[$], exp_q[$];
    logic [31:0] req_a[$];
    int failures = 0, n_checks = 0;
    fdf_front_core uut (.clk_i(clk_i), .rstn_i(rstn_i), .mem_req_o(mreq), .mem_addr_o(maddr),
        .mem_ack_i(mack), .mem_data_i(mdata), .flush_i(flush_i), .flush_pc_i(flush_pc),
        .bp_upd_valid_i(bp_v), .bp_upd_pc_i(bp_pc), .bp_upd_taken_i(bp_tk), .bp_upd_target_i(32'h9E),
        .bp_upd_end_i(4'h0), .port_free_i(port_free), .disp_valid_o(dv), .disp_tag_o(dtag),
        .disp_uop_o(duop), .cmpl_valid_i(cmpl_v), .cmpl_tag_i(cmpl_tag), .retire_cnt_o(rcnt),
        .retire_uop_o(ruop));
    fdf_mem_model mem (.clk_i(clk_i), .rstn_i(rstn_i), .lat_i(lat), .req_i(mreq), .addr_i(maddr),
        .ack_o(mack), .data_o(mdata));
    initial forever #4 clk_i = ~clk_i;
    // ==========
    // Completes youngest first, so the buffer must reorder
    always @(posedge clk_i) begin
        cmpl_v <= 1'b0;
        if (mreq && mack) req_a.push_back(maddr);
        if (flush_i) begin
            tq.delete();
            got.delete();
        end else begin
            for (int i = 0; i < 5; i++) if (dv[i]) tq.push_front(dtag[4*i +: 4]);
            for (int i = 0; i < rcnt; i++) got.push_back(ruop[12*i +: 12]);
            if (tq.size() > 0) begin
                cmpl_v <= 1'b1;
                cmpl_tag <= tq.pop_front();
            end
        end
    end
    task automatic give_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic emit(input logic [7:0] b);
        logic [2:0] c;
        int n;
        c = b[4:2];
        n = (c == 3'h5) ? 3 : (c == 3'h6) ? 4 : (c == 3'h4 || (c == 3'h1 && b[5])) ? 2 : 1;
        for (int k = 0; k < n; k++) exp_q.push_back({b, k[1:0], n == 1 && (c == 3'h1 || c == 3'h2), c == 3'h3});
        mem.prog[a] = b;
        a = a + b[1:0] + 8'h1;
    endtask
    task automatic wait_ret(input int n);
        int t;
        for (t = 0; t < 4000 && got.size() < n; t++) @(posedge clk_i);
        if (got.size() < n) begin
            failures++;
            give_verdict();
        end
    endtask
    task automatic check_stream(input int lo, input int hi);
        for (int k = lo; k < hi; k++) chk("retired uop", exp_q[k], got[k - lo]);
    endtask
    task automatic redirect(input logic [31:0] pc);
        flush_pc <= pc;
        flush_i <= 1'b1;
        @(posedge clk_i);
        flush_i <= 1'b0;
    endtask
    task automatic test_mix();
        wait_ret(23);
        check_stream(0, 23);
        chk("first refill", 32'h0, req_a[0]);
        chk("second refill", 32'h10, req_a[1]);
        $display("test mix done");
    endtask
    task automatic test_refetch();
        int n0, bad;
        bad = 0;
        port_free <= 5'h03;
        n0 = req_a.size();
        redirect(32'h0);
        wait_ret(23);
        check_stream(0, 23);
        for (int k = n0; k < req_a.size(); k++) if (req_a[k] == 32'h0) bad++;
        chk("refills of a cached block", 32'h0, bad);
        $display("test refetch done");
    endtask
    task automatic test_branch();
        port_free <= 5'h1F;
        lat <= 4'h6;
        bp_v <= 1'b1;
        repeat (3) @(posedge clk_i);
        // One not-taken outcome only weakens the saturated counter; still predicted taken
        bp_tk <= 1'b0;
        @(posedge clk_i);
        bp_v <= 1'b0;
        bp_tk <= 1'b1;
        redirect(32'h80);
        wait_ret(6);
        check_stream(23, 29);
        $display("test branch done");
    endtask
    initial begin
        for (int k = 0; k < 256; k++) mem.prog[k] = 8'h00;
        a = 8'h0;
        foreach (mix[k]) emit(mix[k]);
        repeat (4) exp_q.push_back(12'h000);
        a = 8'h80;
        emit(8'h1C);
        // Bytes a wrong fall-through would decode
        for (int k = 8'h81; k < 8'h9E; k++) mem.prog[k] = 8'h14;
        a = 8'h9E;
        emit(8'h20);
        emit(8'h20);
        repeat (3) exp_q.push_back(12'h000);
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'b1;
        test_mix();
        test_refetch();
        test_branch();
        give_verdict();
    end
endmodule
`default_nettype wire
